// ==== include/cfp_pkg.sv ====
// Shared constants and types for the fetch pipeline control block.
// Assumes one clock domain and an 8-bit memory data bus with 24-bit addresses.
package cfp_pkg;

  // ----------------------------------------------------------------------
  // Widths and queue depth
  // ----------------------------------------------------------------------
  localparam int CFP_DATA_W = 8;
  localparam int CFP_ADDR_W = 24;
  localparam int CFP_LOG_W = 16;
  localparam int CFP_PAGE_W = 8;
  localparam int CFP_QUEUE_DEPTH = 4;
  localparam int CFP_QIDX_W = 2;
  localparam int CFP_QCNT_W = 3;

  // ----------------------------------------------------------------------
  // Reset values and queue limits
  // ----------------------------------------------------------------------
  localparam logic [CFP_ADDR_W-1:0] CFP_PC_RESET = 24'h000000;
  localparam logic [CFP_PAGE_W-1:0] CFP_PAGE_RESET = 8'h00;
  localparam logic CFP_LONG_RESET = 1'b0;
  localparam logic [CFP_QCNT_W-1:0] CFP_QCNT_ZERO = 3'h0;
  localparam logic [CFP_QCNT_W-1:0] CFP_QCNT_FULL = 3'h4;

  // ----------------------------------------------------------------------
  // Fetch states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CFP_FS_IDLE = 2'b00,
    CFP_FS_FETCH = 2'b01,
    CFP_FS_HOLD = 2'b10,
    CFP_FS_FLUSH = 2'b11
  } cfp_fetch_state_t;

  // Data bus source selection.
  typedef enum logic [1:0] {
    CFP_SEL_ACC = 2'b00,
    CFP_SEL_LOW = 2'b01,
    CFP_SEL_MID = 2'b10,
    CFP_SEL_HIGH = 2'b11
  } cfp_data_sel_t;

  // One fetched byte with its instruction boundary marks.
  typedef struct packed {
    logic [CFP_DATA_W-1:0] data;
    logic first;
    logic last;
  } cfp_fetch_byte_t;

  // Execute-stage request for a data access on the memory bus.
  typedef struct packed {
    logic valid;
    logic write;
    logic logical;
    logic [CFP_ADDR_W-1:0] addr;
    cfp_data_sel_t sel;
  } cfp_exec_req_t;

  // Processor operating state flags.
  typedef struct packed {
    logic halt;
    logic sleep;
    logic irq;
    logic debug;
    logic long_address_mode;
  } cfp_mode_t;

endpackage : cfp_pkg

// ==== core/cfp_addr_gen.sv ====
// Address generator: forms every 24-bit memory address.
// Assumes the page base is supplied by the caller's register.
`timescale 1ns/1ps
module cfp_addr_gen (
  // Address in
  input wire logic [cfp_pkg::CFP_ADDR_W-1:0] raw_addr,
  input wire logic is_logical,
  // Mode and page
  input wire logic long_address_mode,
  input wire logic [cfp_pkg::CFP_PAGE_W-1:0] memory_page_base,
  // Address out
  output logic [cfp_pkg::CFP_ADDR_W-1:0] phys_addr
);
  import cfp_pkg::*;

  // ----------------------------------------------------------------------
  // Translation
  // ----------------------------------------------------------------------
  // page above logical
  // Short mode prepends the page base to logical addresses; otherwise the full address passes.
  always_comb begin
    if (is_logical && !long_address_mode) begin
      phys_addr = {memory_page_base, raw_addr[CFP_LOG_W-1:0]};
    end else begin
      phys_addr = raw_addr;
    end
  end

endmodule // cfp_addr_gen

// ==== core/cfp_fetch_pipeline.sv ====
// Fetch and pipeline control: prefetch queue, bus arbitration, flush,
// mode tracking and data selection for an 8-bit core with 24-bit values.
// Assumes a single-cycle synchronous memory: read data returns next cycle.
//
// Functional notes
// - State machine fetches opcodes and operands, marks first and last bytes.
// - Fetched bytes are held while the bus serves data reads or writes.
// - Every prefetched byte is dropped on jump, interrupt or transfer.
// - Next instruction is prefetched while current one executes.
// - An execute-phase bus write blocks operand prefetch that cycle.
// - After a transfer, fetching restarts from the new program counter.
// - Address generator forms every address; the page base is held in page_reg.
// - Data moves over 8 bits; values held up to 24 bits.
// - Data selector picks the data bus source per executing instruction.
// - Mode control tracks halt, sleep, interrupt, debug and long mode.
// - Short mode logical address is page base above the 16-bit address.
// - Reset leaves long-address mode cleared.
`timescale 1ns/1ps
module cfp_fetch_pipeline (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Memory bus
  output logic [cfp_pkg::CFP_ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [cfp_pkg::CFP_DATA_W-1:0] mem_wdata,
  input wire logic [cfp_pkg::CFP_DATA_W-1:0] mem_rdata,
  // Decoder side: instruction length and byte consumption
  input wire logic [1:0] instr_len_m1,
  input wire logic len_valid,
  output cfp_pkg::cfp_fetch_byte_t fetch_byte,
  output logic fetch_valid,
  input wire logic fetch_take,
  // Execute side
  input wire cfp_pkg::cfp_exec_req_t exec_req,
  input wire logic [cfp_pkg::CFP_ADDR_W-1:0] exec_value,
  output logic [cfp_pkg::CFP_DATA_W-1:0] exec_rdata,
  output logic exec_rdata_valid,
  // Control transfer
  input wire logic xfer,
  input wire logic [cfp_pkg::CFP_ADDR_W-1:0] xfer_pc,
  // Mode control
  input wire cfp_pkg::cfp_mode_t mode_set,
  input wire cfp_pkg::cfp_mode_t mode_clr,
  input wire logic page_wr,
  input wire logic [cfp_pkg::CFP_PAGE_W-1:0] page_wdata,
  output cfp_pkg::cfp_mode_t mode,
  output logic [cfp_pkg::CFP_PAGE_W-1:0] memory_page_base,
  output logic [cfp_pkg::CFP_ADDR_W-1:0] fetch_pc
);
  import cfp_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  cfp_fetch_state_t state_reg, state_next;
  cfp_fetch_byte_t queue_reg [CFP_QUEUE_DEPTH];
  logic [CFP_QIDX_W-1:0] rd_ptr_reg, wr_ptr_reg;
  logic [CFP_QCNT_W-1:0] count_reg, count_next;
  logic [CFP_ADDR_W-1:0] pc_reg;
  logic [CFP_PAGE_W-1:0] page_reg;
  cfp_mode_t mode_reg;
  logic [1:0] left_reg;
  logic pend_first_reg;
  logic fetch_inflight_reg;
  logic data_inflight_reg;
  logic pend_last;
  logic bus_busy;
  logic may_fetch;
  logic issue_fetch;
  logic push;
  logic pop;
  logic [CFP_ADDR_W-1:0] gen_addr;
  logic [CFP_ADDR_W-1:0] raw_addr;
  logic raw_logical;

  // True when the queue has room for one more byte including one in flight.
  function automatic logic room_left(input logic [CFP_QCNT_W-1:0] cnt, input logic busy);
    room_left = (cnt + {2'b00, busy}) < CFP_QCNT_FULL;
  endfunction

  // ----------------------------------------------------------------------
  // Bus arbitration
  // ----------------------------------------------------------------------
  // write blocks prefetch
  // Execute data accesses always own the bus; fetch takes it when free.
  assign bus_busy = exec_req.valid;
  assign may_fetch = (state_reg == CFP_FS_FETCH) && !mode_reg.halt && !mode_reg.sleep;
  // retry at same address
  // A blocked fetch leaves pc_reg untouched, so the next free cycle reissues it.
  assign issue_fetch = may_fetch && !bus_busy && !xfer
                       && room_left(count_reg, fetch_inflight_reg);

  always_comb begin
    if (bus_busy) begin
      raw_addr = exec_req.addr;
      raw_logical = exec_req.logical;
    end else begin
      raw_addr = pc_reg;
      raw_logical = 1'b1;
    end
  end

  cfp_addr_gen u_addr_gen (
    .raw_addr(raw_addr),
    .is_logical(raw_logical),
    .long_address_mode(mode_reg.long_address_mode),
    .memory_page_base(page_reg),
    .phys_addr(gen_addr)
  );

  // Memory strobes are combinational handshakes; address follows the grant.
  assign mem_addr = gen_addr;
  assign mem_rd = issue_fetch || (exec_req.valid && !exec_req.write);
  assign mem_wr = exec_req.valid && exec_req.write;

  // ----------------------------------------------------------------------
  // Data selector
  // ----------------------------------------------------------------------
  // data bus source
  // byte lanes of 24-bit value
  // Each write moves one byte; the execute stage picks which lane of its value.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mem_wdata <= 8'h00;
    end else begin
      unique case (exec_req.sel)
        CFP_SEL_ACC: mem_wdata <= exec_value[7:0];
        CFP_SEL_LOW: mem_wdata <= exec_value[7:0];
        CFP_SEL_MID: mem_wdata <= exec_value[15:8];
        CFP_SEL_HIGH: mem_wdata <= exec_value[23:16];
      endcase
    end
  end

  // Data read return to the execute stage, two cycles after the request.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_inflight_reg <= 1'b0;
      exec_rdata <= 8'h00;
      exec_rdata_valid <= 1'b0;
    end else begin
      data_inflight_reg <= exec_req.valid && !exec_req.write;
      exec_rdata_valid <= data_inflight_reg;
      if (data_inflight_reg) begin
        exec_rdata <= mem_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Fetch state machine
  // ----------------------------------------------------------------------
  // fetch state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CFP_FS_IDLE: state_next = CFP_FS_FETCH;
      CFP_FS_FETCH: begin
        if (xfer) begin
          state_next = CFP_FS_FLUSH;
        end else if (mode_reg.halt || mode_reg.sleep) begin
          state_next = CFP_FS_HOLD;
        end
      end
      CFP_FS_HOLD: begin
        if (xfer) begin
          state_next = CFP_FS_FLUSH;
        end else if (!mode_reg.halt && !mode_reg.sleep) begin
          state_next = CFP_FS_FETCH;
        end
      end
      CFP_FS_FLUSH: state_next = CFP_FS_FETCH;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= CFP_FS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // restart at new PC
  // Program counter advances only when a fetch really went to the bus.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pc_reg <= CFP_PC_RESET;
    end else if (xfer) begin
      pc_reg <= xfer_pc;
    end else if (issue_fetch) begin
      pc_reg <= pc_reg + 24'h000001;
    end
  end

  // In-flight fetch tracking; a transfer kills the byte on its way back.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fetch_inflight_reg <= 1'b0;
    end else begin
      fetch_inflight_reg <= issue_fetch;
    end
  end

  // ----------------------------------------------------------------------
  // Boundary marking
  // ----------------------------------------------------------------------
  // first and last marks
  // Length arrives from the decoder with the opcode; a one-byte instruction
  // is both first and last. Bytes after the boundary start the next one.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      left_reg <= 2'h0;
      pend_first_reg <= 1'b1;
    end else if (xfer) begin
      left_reg <= 2'h0;
      pend_first_reg <= 1'b1;
    end else if (push) begin
      if (pend_first_reg) begin
        left_reg <= len_valid ? instr_len_m1 : 2'h0;
        pend_first_reg <= !len_valid || (instr_len_m1 == 2'h0);
      end else begin
        left_reg <= left_reg - 2'h1;
        pend_first_reg <= (left_reg == 2'h1);
      end
    end
  end

  assign pend_last = pend_first_reg ? (!len_valid || instr_len_m1 == 2'h0)
                                    : (left_reg == 2'h1);

  // ----------------------------------------------------------------------
  // Prefetch queue
  // ----------------------------------------------------------------------
  // drop on transfer
  // hold during data access
  // The returning byte is discarded if a transfer lands in the same cycle.
  assign push = fetch_inflight_reg && !xfer;
  assign pop = fetch_valid && fetch_take && !xfer;

  always_comb begin
    count_next = count_reg;
    if (xfer) begin
      count_next = CFP_QCNT_ZERO;
    end else if (push && !pop) begin
      count_next = count_reg + 3'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_reg <= CFP_QCNT_ZERO;
      rd_ptr_reg <= 2'h0;
      wr_ptr_reg <= 2'h0;
    end else begin
      count_reg <= count_next;
      if (xfer) begin
        rd_ptr_reg <= 2'h0;
        wr_ptr_reg <= 2'h0;
      end else begin
        if (push) begin
          wr_ptr_reg <= wr_ptr_reg + 2'h1;
        end
        if (pop) begin
          rd_ptr_reg <= rd_ptr_reg + 2'h1;
        end
      end
    end
  end

  // prefetch while executing
  // Queue storage; entries persist until consumed by the decoder or dropped by a transfer.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < CFP_QUEUE_DEPTH; i++) begin
        queue_reg[i] <= '0;
      end
    end else if (push) begin
      queue_reg[wr_ptr_reg] <= '{data: mem_rdata, first: pend_first_reg, last: pend_last};
    end
  end

  assign fetch_valid = (count_reg != CFP_QCNT_ZERO);
  assign fetch_byte = queue_reg[rd_ptr_reg];
  assign fetch_pc = pc_reg;

  // ----------------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------------
  // operating state
  // reset in short mode
  // Set wins over clear so a same-cycle event is never lost.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_reg <= '{halt: 1'b0, sleep: 1'b0, irq: 1'b0, debug: 1'b0,
                    long_address_mode: CFP_LONG_RESET};
    end else begin
      mode_reg <= (mode_reg & ~mode_clr) | mode_set;
    end
  end

  // page base register
  // The page base may only change while in long mode, guarding short-mode code.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      page_reg <= CFP_PAGE_RESET;
    end else if (page_wr && mode_reg.long_address_mode) begin
      page_reg <= page_wdata;
    end
  end

  assign mode = mode_reg;
  assign memory_page_base = page_reg;

endmodule // cfp_fetch_pipeline

// ==== tb/cfp_fetch_pipeline_monitor.sv ====
// Concurrent checks on the fetch pipeline ports.
// Assumes one clock and the bind at the foot of this file.
`timescale 1ns/1ps
module cfp_fetch_pipeline_monitor
  import cfp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Memory bus
  input wire logic [23:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  // Decoder and execute
  input wire cfp_fetch_byte_t fetch_byte,
  input wire logic fetch_valid,
  input wire logic fetch_take,
  input wire cfp_exec_req_t exec_req,
  input wire logic [23:0] exec_value,
  input wire logic exec_rdata_valid,
  // Transfer and mode
  input wire logic xfer,
  input wire cfp_mode_t mode,
  input wire logic [7:0] memory_page_base,
  input wire logic [23:0] fetch_pc
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  logic [7:0] lane_q;
  wire lng = mode.long_address_mode;
  wire [23:0] exp_exec = (exec_req.logical && !lng) ?
      {memory_page_base, exec_req.addr[15:0]} : exec_req.addr;
  // Lane due on the bus one cycle after the write request.
  always_ff @(posedge clock) begin
    lane_q <= 8'(exec_value >> (8 * (int'(exec_req.sel) - 1)));
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_fetch;
    mem_rd && !exec_req.valid && !xfer;
  endsequence
  sequence s_exec_rd;
    exec_req.valid && !exec_req.write;
  endsequence
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_fetch_fills_queue: assert property (s_fetch ##1 !xfer |=> fetch_valid)
    else $error("fetched byte never reached the queue");
  a_flush_on_xfer: assert property (xfer |=> !fetch_valid)
    else $error("queue not emptied by a transfer");
  a_head_held: assert property (fetch_valid && !fetch_take && !xfer |=>
      fetch_valid && $stable(fetch_byte)) else $error("queue head lost or changed");
  a_exec_owns_bus: assert property (exec_req.valid |-> mem_wr == exec_req.write
      && !(mem_rd && mem_wr) && mem_addr == exp_exec) else $error("exec access wrong");
  a_fetch_addr_map: assert property (s_fetch |-> mem_addr[15:0] == fetch_pc[15:0]
      && mem_addr[23:16] == (lng ? fetch_pc[23:16] : memory_page_base))
    else $error("fetch address not translated");
  a_wdata_lane: assert property (mem_wr && exec_req.sel != CFP_SEL_ACC |=>
      mem_wdata == lane_q) else $error("write data lane wrong");
  a_rdata_two_cyc: assert property (s_exec_rd |-> ##2 exec_rdata_valid)
    else $error("exec read data late");
  a_page_locked: assert property (!lng |=> $stable(memory_page_base))
    else $error("page base changed in short mode");
  a_retry_same_pc: assert property (exec_req.valid && exec_req.write && !xfer
      |=> fetch_pc == $past(fetch_pc)) else $error("fetch address moved");
endmodule // cfp_fetch_pipeline_monitor

bind cfp_fetch_pipeline cfp_fetch_pipeline_monitor cfp_fetch_pipeline_monitor_i (
  .clock, .rst_n, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .fetch_byte, .fetch_valid,
  .fetch_take, .exec_req, .exec_value, .exec_rdata_valid, .xfer, .mode,
  .memory_page_base, .fetch_pc);

// ==== tb/cfp_mem_model.sv ====
// Behavioural program and data memory on the far side of the bus.
// Assumes read data is due the cycle after the strobe.
`timescale 1ns/1ps
module cfp_mem_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Memory bus
  input wire logic [23:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] wmem [16];
  logic wr_q;
  logic [3:0] wa_q;
  // Contents are a pattern of the address, so a wrong address shows.
  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16];
  endfunction
  // Outside a read the line toggles, so stale data never passes.
  always_ff @(posedge clock) begin
    if (!rst_n) mem_rdata <= 8'ha5;
    else if (mem_rd) mem_rdata <= pat(mem_addr);
    else mem_rdata <= ~mem_rdata;
  end
  // Write data arrives one cycle after the strobe.
  always_ff @(posedge clock) begin
    wr_q <= mem_wr;
    wa_q <= mem_addr[3:0];
    if (wr_q) wmem[wa_q] <= mem_wdata;
  end
endmodule // cfp_mem_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the fetch pipeline with a memory model.
// Assumes inputs change on the falling clock edge.
`timescale 1ns/1ps
module tb_top;
  import cfp_pkg::*;
  logic clock = 0, rst_n = 0, mem_rd, mem_wr, len_valid = 1, fetch_valid;
  logic fetch_take = 0, exec_rdata_valid, xfer = 0, page_wr = 0;
  logic [23:0] mem_addr, exec_value = 24'hc3b2a1, xfer_pc = 0, fetch_pc;
  logic [7:0] mem_wdata, mem_rdata, exec_rdata, page_wdata = 8'h37, memory_page_base;
  logic [1:0] instr_len_m1 = 2'd2;
  cfp_fetch_byte_t fetch_byte;
  cfp_exec_req_t exec_req = '0;
  cfp_mode_t mode_set = '0, mode_clr = '0, mode;
  int failures = 0, cmp_count = 0;

  cfp_fetch_pipeline cfp_fetch_pipeline_i (.clock, .rst_n, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata, .instr_len_m1, .len_valid, .fetch_byte, .fetch_valid,
    .fetch_take, .exec_req, .exec_value, .exec_rdata, .exec_rdata_valid, .xfer, .xfer_pc,
    .mode_set, .mode_clr, .page_wr, .page_wdata, .mode, .memory_page_base, .fetch_pc);
  cfp_mem_model cfp_mem_model_i (.clock, .rst_n, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata);

  // Free-running 250 MHz clock.
  always #2 clock = ~clock;

  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16];
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Waits for a byte under a bound, checks it and pops it.
  task automatic pop(input logic [23:0] a, input logic f, input logic l);
    for (int n = 0; n < 50 && fetch_valid !== 1'b1; n++) @(negedge clock);
    chk({fetch_valid, fetch_byte.first, fetch_byte.last, fetch_byte.data},
        {1'b1, f, l, pat(a)});
    fetch_take = 1;
    @(negedge clock);
    fetch_take = 0;
    // Let an edge pass with take low so a following pop never re-raises it at once.
    @(negedge clock);
  endtask
  task automatic jump(input logic [23:0] a);
    xfer = 1;
    xfer_pc = a;
    @(negedge clock);
    xfer = 0;
  endtask
  task automatic t_reset;
    repeat (3) @(negedge clock);
    chk({mode, memory_page_base, fetch_valid}, 24'h0);
    chk(fetch_pc, 24'h0);
    rst_n = 1;
    for (int i = 1; i < 5; i++) begin
      mode_set = cfp_mode_t'(5'(1 << i));
      mode_clr = mode_set;
      @(negedge clock);
      chk(24'(mode), 24'(1 << i));
      mode_set = '0;
      @(negedge clock);
      chk(24'(mode), 24'h0);
      mode_clr = '0;
    end
  endtask
  task automatic t_fetch;
    for (int i = 0; i < 6; i++) pop(24'(i), i % 3 == 0, i % 3 == 2);
  endtask
  // Writes right after a jump keep the bus, so the restart fetch waits.
  task automatic t_xfer_write;
    logic [23:0] pc;
    jump(24'h001230);
    chk(24'(fetch_valid), 24'h0);
    pc = fetch_pc;
    for (int i = 1; i < 4; i++) begin
      exec_req = '{1'b1, 1'b1, 1'b0, 24'h00abc0 + 24'(i), cfp_data_sel_t'(i)};
      #1 chk({mem_wr, mem_rd}, 24'h2);
      @(negedge clock);
    end
    exec_req = '0;
    chk(fetch_pc, pc);
    for (int i = 0; i < 3; i++) pop(24'h001230 + 24'(i), i == 0, i == 2);
    for (int i = 1; i < 4; i++) chk(cfp_mem_model_i.wmem[i],
                                    8'(exec_value >> (8 * (i - 1))));
  endtask
  task automatic t_read;
    cfp_fetch_byte_t hd;
    repeat (6) @(negedge clock);
    hd = fetch_byte;
    exec_req = '{1'b1, 1'b0, 1'b1, 24'hff0077, CFP_SEL_ACC};
    @(negedge clock);
    exec_req = '0;
    @(negedge clock);
    chk({exec_rdata_valid, exec_rdata}, {1'b1, pat(24'h000077)});
    chk({fetch_valid, fetch_byte}, {1'b1, hd});
  endtask
  task automatic t_mode;
    page_wr = 1;
    @(negedge clock);
    page_wr = 0;
    chk(memory_page_base, 24'h0);
    mode_set.long_address_mode = 1;
    @(negedge clock);
    mode_set = '0;
    page_wr = 1;
    @(negedge clock);
    page_wr = 0;
    chk({mode.long_address_mode, memory_page_base}, 24'h137);
    jump(24'h451234);
    pop(24'h451234, 1, 0);
    mode_clr.long_address_mode = 1;
    @(negedge clock);
    mode_clr = '0;
    jump(24'h001234);
    pop(24'h371234, 1, 0);
  endtask
  // Two-byte lengths, then no length qualifier, with a halt keeping the bus quiet.
  task automatic t_len;
    instr_len_m1 = 2'd1;
    jump(24'h002000);
    for (int i = 0; i < 4; i++) pop(24'h372000 + 24'(i), i % 2 == 0, i % 2 == 1);
    len_valid = 0;
    mode_set.halt = 1;
    jump(24'h003000);
    mode_set = '0;
    repeat (3) begin
      #1 chk({mem_rd, fetch_valid}, 24'h0);
      @(negedge clock);
    end
    mode_clr.halt = 1;
    @(negedge clock);
    mode_clr = '0;
    for (int i = 0; i < 2; i++) pop(24'h373000 + 24'(i), 1, 1);
  endtask

  task automatic end_of_test;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence.
  initial begin
    t_reset();
    t_fetch();
    t_xfer_write();
    t_read();
    t_mode();
    t_len();
    end_of_test();
  end
  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    #20000;
    failures++;
    end_of_test();
  end
endmodule // tb_top
